// [common/opconv_pkg.sv]
/*
 Constants for the accumulator and operand convention unit: register
 offsets, command field positions, mode codes and reset values.
 Assumes an APB slave with 32-bit data and byte addresses.
*/
`default_nettype none
package opconv_pkg;
	// Register byte offsets
	localparam logic [7:0] R_CMD = 8'h00;
	localparam logic [7:0] R_IMM = 8'h04;
	localparam logic [7:0] R_ACC = 8'h08;
	localparam logic [7:0] R_FLAGS = 8'h0c;
	localparam logic [7:0] R_BANK = 8'h18;
	localparam logic [7:0] R_SP = 8'h1c;
	localparam logic [7:0] R_MEM_IDX = 8'h20;
	localparam logic [7:0] R_MEM_DATA = 8'h24;
	localparam logic [7:0] R_EA_CFG = 8'h28;
	localparam logic [7:0] R_EA_ADDR = 8'h2c;
	localparam logic [7:0] R_VEC = 8'h30;
	localparam logic [2:0] R_GPR_PAGE = 3'h2;
	// Command field positions
	localparam int F_WIDTH = 0;
	localparam int F_LH = 2;
	localparam int F_AH = 4;
	localparam int F_RMW = 6;
	localparam int F_ADD = 7;
	localparam int F_FLAGOPS = 8;
	localparam int F_SRC = 22;
	localparam int F_REG = 24;
	localparam int F_IMMF = 27;
	// Flag bit positions
	localparam int FL_I = 6;
	localparam int FL_S = 5;
	localparam int FL_T = 4;
	localparam int FL_N = 3;
	localparam int FL_Z = 2;
	localparam int FL_V = 1;
	localparam int FL_C = 0;
	// Operand widths
	localparam logic [1:0] W_BYTE = 2'h0;
	localparam logic [1:0] W_WORD = 2'h1;
	// Lower half high byte treatment
	localparam logic [1:0] LH_KEEP = 2'h0;
	localparam logic [1:0] LH_ZERO = 2'h1;
	localparam logic [1:0] LH_SIGN = 2'h2;
	// Upper half treatment
	localparam logic [1:0] AH_KEEP = 2'h0;
	localparam logic [1:0] AH_COPY = 2'h1;
	localparam logic [1:0] AH_ZERO = 2'h2;
	localparam logic [1:0] AH_SIGN = 2'h3;
	// Flag treatment
	localparam logic [1:0] FOP_KEEP = 2'h0;
	localparam logic [1:0] FOP_UPD = 2'h1;
	localparam logic [1:0] FOP_SET = 2'h2;
	localparam logic [1:0] FOP_CLR = 2'h3;
	// Operand sources
	localparam logic [1:0] SRC_IMM = 2'h0;
	localparam logic [1:0] SRC_WORD = 2'h1;
	localparam logic [1:0] SRC_BYTE = 2'h2;
	// Immediate forms
	localparam logic [2:0] IMM_4 = 3'h0;
	localparam logic [2:0] IMM_8 = 3'h1;
	localparam logic [2:0] IMM_16 = 3'h2;
	localparam logic [2:0] IMM_EXT8 = 3'h4;
	// Effective address modes
	localparam logic [1:0] EA_IO = 2'h0;
	localparam logic [1:0] EA_DISP8 = 2'h1;
	localparam logic [1:0] EA_DISP16 = 2'h2;
	// Bank register indices (group one codes)
	localparam logic [2:0] BK_DATA = 3'h0;
	localparam logic [2:0] BK_SYS_STACK = 3'h2;
	localparam logic [2:0] BK_USER_STACK = 3'h3;
	localparam logic [2:0] BK_PROGRAM = 3'h5;
	localparam logic [2:0] BK_CUR_STACK = 3'h6;
	localparam logic [2:0] BK_NONE = 3'h7;
	// Reset values
	localparam logic [31:0] ACC_RST = 32'h0000_0000;
	localparam logic [6:0] FLAGS_RST = 7'h00;
	localparam logic [7:0] BANK_RST = 8'h00;
endpackage : opconv_pkg
`default_nettype wire

// [src/acc_operand_unit.sv]
/*
 Accumulator and operand convention unit with an APB register slave.
 Assumes APB from logic on CLK_IN, so no synchroniser; one wait state.
// Operation
// - Accumulator width per command: byte low 8, word low 16, long all 32 bits.
// - Lower half bits 15 to 8: zeroed, sign copied from bit 7, or kept.
// - Upper half: copy of lower half, zero, sign fill, or unchanged.
// - Each of seven flags kept, updated from result, set, or cleared.
// - Read-modify-write reads, processes and writes back memory in one step.
// - Short I/O addressing reaches only 000000 to 0000FF, low byte from instruction.
// - Vector number from 4-bit field 0 to 15 or 8-bit field 0 to 255.
// - Eight byte, eight word, four long registers; only first four words are pointers.
// - Immediates of 4, 8, 16, 32 bits; extended byte sign-extends to 16 bits.
// - Pointer displacement is 8 or 16 bits by encoding.
// - Active stack pointer and stack bank follow the stack select flag.
// - Bank group one includes program bank; group two excludes it.
*/
`timescale 1ns/10ps
`default_nettype none
module acc_operand_unit
	import opconv_pkg::*;
#(
	parameter int MEM_WORDS = 16
) (
	// Clock, reset, enable
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic CE_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Datapath state
	output logic [31:0] ACC_OUT,
	output logic [6:0] FLAGS_OUT
);
	localparam int MIW = $clog2(MEM_WORDS);

	logic [31:0] acc;
	logic [6:0] flags;
	logic [15:0] word_gp_reg [8];
	logic [15:0] mem [MEM_WORDS];
	logic [MIW-1:0] mem_idx;
	logic [31:0] cmd, imm, ea_cfg;
	logic [7:0] bank [6];
	logic [2:0] bank_sel;
	logic [15:0] user_stack_pointer, system_stack_pointer;
	logic ack;

	// Signed add in a scaled frame so the width's top bit sits at bit 31
	function automatic logic [35:0] alu_f(input logic [1:0] w, input logic add,
		input logic [31:0] d, input logic [31:0] o);
		logic [4:0] sh;
		logic [31:0] ds, os, rs;
		logic [32:0] s;
		logic v;
		sh = (w == W_BYTE) ? 5'h18 : (w == W_WORD) ? 5'h10 : 5'h00;
		ds = d << sh;
		os = o << sh;
		s = add ? ({1'b0, ds} + {1'b0, os}) : {1'b0, os};
		rs = s[31:0];
		v = add & (ds[31] == os[31]) & (rs[31] != ds[31]);
		alu_f = {rs[31], rs == 32'h0, v, s[32] & add, rs >> sh};
	endfunction : alu_f

	// Per-flag treatment
	function automatic logic [6:0] flag_f(input logic [13:0] ops, input logic [6:0] cur,
		input logic [6:0] res);
		flag_f = cur;
		for (int i = 0; i < 7; i++) begin
			case (ops[2*i +: 2])
				FOP_UPD: flag_f[i] = res[i];
				FOP_SET: flag_f[i] = 1'b1;
				FOP_CLR: flag_f[i] = 1'b0;
				default: flag_f[i] = cur[i];
			endcase
		end
	endfunction : flag_f

	// Bank code to storage index; group two has no program bank code
	function automatic logic [2:0] bank_map(input logic grp2, input logic [2:0] code);
		if (!grp2)
			bank_map = code;
		else if (code == 3'h5)
			bank_map = BK_CUR_STACK;
		else if (code < 3'h5)
			bank_map = code;
		else
			bank_map = BK_NONE;
	endfunction : bank_map

	// APB phases: first access cycle loads data, second answers
	wire access = PSEL_IN & PENABLE_IN & CE_IN;
	wire done = access & ack;
	wire wr = done & PWRITE_IN;
	wire gpr_hit = PADDR_IN[7:5] == R_GPR_PAGE && PADDR_IN[1:0] == 2'h0;
	wire exec = wr & (PADDR_IN == R_CMD);

	// Command fields from the write data of the executing access
	wire [1:0] c_width = PWDATA_IN[F_WIDTH +: 2];
	wire [1:0] c_lh = PWDATA_IN[F_LH +: 2];
	wire [1:0] c_ah = PWDATA_IN[F_AH +: 2];
	wire c_rmw = PWDATA_IN[F_RMW];
	wire c_add = PWDATA_IN[F_ADD];
	wire [13:0] c_fops = PWDATA_IN[F_FLAGOPS +: 14];
	wire [1:0] c_src = PWDATA_IN[F_SRC +: 2];
	wire [2:0] c_reg = PWDATA_IN[F_REG +: 3];
	wire [2:0] c_immf = PWDATA_IN[F_IMMF +: 3];

	wire [31:0] imm_val = (c_immf == IMM_4) ? {28'h0, imm[3:0]} :
		(c_immf == IMM_8) ? {24'h0, imm[7:0]} :
		(c_immf == IMM_16) ? {16'h0, imm[15:0]} :
		(c_immf == IMM_EXT8) ? {16'h0, {8{imm[7]}}, imm[7:0]} : imm;
	// byte registers overlay the upper four words, longs pair words
	wire [15:0] byte_word = word_gp_reg[{1'b1, c_reg[2:1]}];
	wire [7:0] byte_gp_reg = c_reg[0] ? byte_word[15:8] : byte_word[7:0];
	wire [31:0] long_gp_reg = {word_gp_reg[{c_reg[1:0], 1'b1}], word_gp_reg[{c_reg[1:0], 1'b0}]};
	wire [31:0] opd = (c_src == SRC_IMM) ? imm_val :
		(c_src == SRC_WORD) ? {16'h0, word_gp_reg[c_reg]} :
		(c_src == SRC_BYTE) ? {24'h0, byte_gp_reg} : long_gp_reg;

	// destination is memory for read-modify-write, else the accumulator
	wire [31:0] dst = c_rmw ? {16'h0, mem[mem_idx]} : acc;
	wire [35:0] alu = alu_f(c_width, c_add, dst, opd);
	wire [31:0] res = alu[31:0];
	// Interrupt and stack select have no result value; sticky gathers carries
	wire [6:0] res_flags = {flags[FL_I], flags[FL_S], flags[FL_T] | alu[32], alu[35:32]};

	// high byte of the lower half on byte results
	wire [7:0] lh_byte = (c_lh == LH_ZERO) ? 8'h00 :
		(c_lh == LH_SIGN) ? {8{res[7]}} : acc[15:8];
	wire [15:0] acc_lower_half = (c_width == W_BYTE) ? {lh_byte, res[7:0]} : res[15:0];
	// upper half treatment, long results own the whole upper half
	wire [15:0] acc_upper_half = (c_width > W_WORD) ? res[31:16] :
		(c_ah == AH_COPY) ? acc_lower_half :
		(c_ah == AH_ZERO) ? 16'h0000 :
		(c_ah == AH_SIGN) ? {16{acc_lower_half[15]}} : acc[31:16];
	// untouched parts keep their old bits
	wire [31:0] next_acc = {acc_upper_half, acc_lower_half};
	wire [6:0] next_flags = flag_f(c_fops, flags, res_flags);
	wire [15:0] next_mem = (c_width == W_BYTE) ? {dst[15:8], res[7:0]} : res[15:0];

	// stack pointer and stack bank follow the stack select flag
	wire sys_stack = flags[FL_S];
	wire [15:0] sp_act = sys_stack ? system_stack_pointer : user_stack_pointer;
	wire [2:0] cur_stack = sys_stack ? BK_SYS_STACK : BK_USER_STACK;
	// group decode; stored index resolves the current stack bank
	wire [2:0] bk_code = bank_map(PWDATA_IN[3], PWDATA_IN[2:0]);
	wire [2:0] bk_phys_w = (bk_code == BK_CUR_STACK) ? cur_stack : bk_code;
	wire [2:0] bk_phys_r = (bank_sel == BK_CUR_STACK) ? cur_stack : bank_sel;
	wire bank_bad = PWRITE_IN && PADDR_IN == R_BANK && bk_code == BK_NONE;

	// Effective address: mode, pointer, fields
	wire [15:0] ea_a16 = ea_cfg[15:0];
	wire [7:0] ea_b8 = ea_cfg[23:16];
	wire [1:0] ea_mode = ea_cfg[25:24];
	// only the first four word registers are pointers
	wire [15:0] ptr = word_gp_reg[{1'b0, ea_cfg[27:26]}];
	// eight-bit displacement is signed, sixteen-bit one is full width
	wire [15:0] disp = (ea_mode == EA_DISP8) ? {{8{ea_b8[7]}}, ea_b8} : ea_a16;
	// I/O area is the first 256 bytes; direct joins two fields
	wire [23:0] ea_addr = (ea_mode == EA_IO) ? {16'h0000, ea_b8} :
		(ea_mode == EA_DISP16 || ea_mode == EA_DISP8) ? {bank[BK_DATA], ptr + disp} :
		{ea_b8, ea_a16};
	// short vector field keeps only four bits
	wire [7:0] vec = ea_cfg[28] ? {4'h0, ea_b8[3:0]} : ea_b8;

	// Read selection and decode
	logic [31:0] rdata;
	logic mapped;
	always_comb begin
		mapped = 1'b1;
		rdata = 32'h0;
		if (gpr_hit)
			rdata = {16'h0, word_gp_reg[PADDR_IN[4:2]]};
		else begin
			case (PADDR_IN)
				R_CMD: rdata = cmd;
				R_IMM: rdata = imm;
				R_ACC: rdata = acc;
				R_FLAGS: rdata = {25'h0, flags};
				R_BANK: rdata = {16'h0, bank[bk_phys_r], 5'h0, bank_sel};
				R_SP: rdata = {16'h0, sp_act};
				R_MEM_IDX: rdata = {{(32 - MIW){1'b0}}, mem_idx};
				R_MEM_DATA: rdata = {16'h0, mem[mem_idx]};
				R_EA_CFG: rdata = ea_cfg;
				R_EA_ADDR: rdata = {8'h0, ea_addr};
				R_VEC: rdata = {24'h0, vec};
				default: mapped = 1'b0;
			endcase
		end
	end

	// APB answer: one wait state, data and error held in flops
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			ack <= 1'b0;
			PRDATA_OUT <= 32'h0;
			PSLVERR_OUT <= 1'b0;
		end else if (CE_IN) begin
			ack <= access & ~ack;
			if (access & ~ack) begin
				PRDATA_OUT <= PWRITE_IN ? 32'h0 : rdata;
				PSLVERR_OUT <= ~mapped | bank_bad;
			end
		end
	end

	// Datapath and register writes
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			acc <= ACC_RST;
			flags <= FLAGS_RST;
			cmd <= 32'h0;
			imm <= 32'h0;
			ea_cfg <= 32'h0;
			mem_idx <= '0;
			bank_sel <= BK_DATA;
			user_stack_pointer <= 16'h0;
			system_stack_pointer <= 16'h0;
			for (int i = 0; i < 6; i++)
				bank[i] <= BANK_RST;
		end else if (exec) begin
			cmd <= PWDATA_IN;
			flags <= next_flags;
			// memory case leaves the accumulator alone
			if (!c_rmw)
				acc <= next_acc;
		end else if (wr && !PSLVERR_OUT) begin
			case (PADDR_IN)
				R_IMM: imm <= PWDATA_IN;
				R_ACC: acc <= PWDATA_IN;
				R_FLAGS: flags <= PWDATA_IN[6:0];
				R_EA_CFG: ea_cfg <= PWDATA_IN;
				R_MEM_IDX: mem_idx <= PWDATA_IN[MIW-1:0];
				R_SP: begin
					if (sys_stack)
						system_stack_pointer <= PWDATA_IN[15:0];
					else
						user_stack_pointer <= PWDATA_IN[15:0];
				end
				R_BANK: begin
					bank_sel <= bk_code;
					if (PWDATA_IN[4])
						bank[bk_phys_w] <= PWDATA_IN[15:8];
				end
				default: ;
			endcase
		end
	end

	// Register file and operand memory
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			for (int i = 0; i < 8; i++)
				word_gp_reg[i] <= 16'h0;
			for (int i = 0; i < MEM_WORDS; i++)
				mem[i] <= 16'h0;
		end else begin
			if (wr && gpr_hit)
				word_gp_reg[PADDR_IN[4:2]] <= PWDATA_IN[15:0];
			// one indivisible read, process and write back
			if (exec && c_rmw)
				mem[mem_idx] <= next_mem;
			else if (wr && PADDR_IN == R_MEM_DATA)
				mem[mem_idx] <= PWDATA_IN[15:0];
		end
	end

	assign PREADY_OUT = ack;
	assign ACC_OUT = acc;
	assign FLAGS_OUT = flags;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	property p_ready_once;
		PREADY_OUT && CE_IN |=> !PREADY_OUT;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("pready held two cycles");

	property p_lh_zero;
		exec && !c_rmw && c_width == W_BYTE && c_lh == LH_ZERO |=> acc[15:8] == 8'h00;
	endproperty
	a_lh_zero: assert property (p_lh_zero) else $error("high byte not zeroed");
	property p_lh_sign;
		exec && !c_rmw && c_width == W_BYTE && c_lh == LH_SIGN |=> acc[15:8] == {8{acc[7]}};
	endproperty
	a_lh_sign: assert property (p_lh_sign) else $error("high byte not sign filled");
	property p_ah_copy;
		exec && !c_rmw && c_width != 2'h2 && c_width != 2'h3 && c_ah == AH_COPY
			|=> acc[31:16] == acc[15:0];
	endproperty
	a_ah_copy: assert property (p_ah_copy) else $error("upper half not a copy");
	property p_keep;
		exec && !c_rmw && c_width == W_BYTE && c_lh == LH_KEEP && c_ah == AH_KEEP
			|=> acc[31:8] == $past(acc[31:8]);
	endproperty
	a_keep: assert property (p_keep) else $error("unproduced bits changed");
	property p_flag_set;
		exec && c_fops[2*FL_C +: 2] == FOP_SET ##1 !exec |-> flags[FL_C];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("carry not set");
	property p_rmw_acc;
		exec && c_rmw |=> acc == $past(acc);
	endproperty
	a_rmw_acc: assert property (p_rmw_acc) else $error("rmw touched accumulator");
	property p_io;
		ea_mode == EA_IO |-> ea_addr[23:8] == 16'h0000 && ea_addr[7:0] == ea_cfg[23:16];
	endproperty
	a_io: assert property (p_io) else $error("io address outside area");
	property p_vec;
		ea_cfg[28] |-> vec < 8'h10;
	endproperty
	a_vec: assert property (p_vec) else $error("short vector above 15");
	property p_sp;
		flags[FL_S] |-> sp_act == system_stack_pointer;
	endproperty
	a_sp: assert property (p_sp) else $error("wrong stack pointer");
	property p_grp2;
		access && !ack && PADDR_IN == R_BANK && PWRITE_IN && PWDATA_IN[3]
			&& PWDATA_IN[2:0] > 3'h5 |=> PSLVERR_OUT;
	endproperty
	a_grp2: assert property (p_grp2) else $error("bad group two code accepted");
endmodule : acc_operand_unit
`default_nettype wire

// [test/test_acc_operand_unit.sv]
/*
 Self-checking bench for the accumulator and operand convention unit.
 Assumes the unit answers APB one cycle after the access phase and that
 commands written to the command register execute at the taking edge.
*/
`timescale 1ns/10ps
`default_nettype none
module test_acc_operand_unit;
	import opconv_pkg::*;
	// Stimulus and observed signals
	logic clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, acc;
	logic pready, pslverr;
	logic [6:0] flags;
	// Model state
	int fails = 0, checks = 0, cycles = 0;
	integer seed = 32'h052a;
	logic [31:0] macc = 32'h0, rdata, r, imm, op;
	logic [6:0] mfl = 7'h0;
	logic [15:0] wreg[8];
	logic err;

	acc_operand_unit #(.MEM_WORDS(16)) dut (.CLK_IN(clk), .RESETN_IN(resetn), .CE_IN(ce), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ACC_OUT(acc), .FLAGS_OUT(flags));

	// Free running clock
	always #4 clk = ~clk;

	// Hang guard: under two hundred transfers need far fewer cycles than this
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			$display("unexpected timeout: expected completion, seen cycle %0d", cycles);
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle keeps a following setup out of this time step
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rdata);
	endtask : rd

	function automatic logic [31:0] cmd(input logic [1:0] w, lh, ah, input logic read_modify_write_insn, add, input logic [13:0] fo,
		input logic [1:0] src, input logic [2:0] rg, input logic [2:0] imf);
		return {2'h0, imf, rg, src, fo, add, read_modify_write_insn, ah, lh, w};
	endfunction : cmd

	function automatic logic [31:0] opval(input logic [2:0] imf, input logic [31:0] v);
		case (imf)
			IMM_4: return {28'h0, v[3:0]};
			IMM_8: return {24'h0, v[7:0]};
			IMM_16: return {16'h0, v[15:0]};
			IMM_EXT8: return {16'h0, {8{v[7]}}, v[7:0]};
			default: return v;
		endcase
	endfunction : opval

	// Reference load or add: width placement, high byte and upper half treatment, flags
	task automatic model(input logic [1:0] w, lh, ah, input logic [31:0] v, input logic [13:0] fo,
		input logic add);
		logic [15:0] lo, hi;
		logic n, z, cy, ov;
		logic [1:0] f;
		logic [32:0] s, m;
		int nb;
		nb = w[1] ? 32 : w[0] ? 16 : 8;
		m = (33'h1 << nb) - 33'h1;
		// Add works at the operand width; carry is the bit just above it
		s = add ? ({1'b0, macc} & m) + ({1'b0, v} & m) : {1'b0, v};
		cy = add & s[nb];
		ov = add & (macc[nb - 1] == v[nb - 1]) & (s[nb - 1] != macc[nb - 1]);
		v = s[31:0];
		if (w[1]) begin
			macc = v;
			n = v[31];
			z = (v == 32'h0);
		end else begin
			lo = (w == W_WORD) ? v[15:0] : {(lh == LH_ZERO) ? 8'h00 : (lh == LH_SIGN) ? {8{v[7]}} : macc[15:8], v[7:0]};
			n = w[0] ? lo[15] : lo[7];
			z = w[0] ? (lo == 16'h0) : (lo[7:0] == 8'h00);
			case (ah)
				AH_COPY: hi = lo;
				AH_ZERO: hi = 16'h0;
				AH_SIGN: hi = {16{lo[15]}};
				default: hi = macc[31:16];
			endcase
			macc = {hi, lo};
		end
		for (int i = 0; i < 7; i++) begin
			f = fo[2*i +: 2];
			if (f == FOP_SET) mfl[i] = 1'b1;
			else if (f == FOP_CLR) mfl[i] = 1'b0;
			else if (f == FOP_UPD && i == FL_N) mfl[i] = n;
			else if (f == FOP_UPD && i == FL_Z) mfl[i] = z;
			else if (f == FOP_UPD && i == FL_V) mfl[i] = ov;
			else if (f == FOP_UPD && i == FL_C) mfl[i] = cy;
			else if (f == FOP_UPD && i == FL_T) mfl[i] = mfl[i] | cy;
		end
	endtask : model

	task automatic run_cmd(input logic [31:0] c);
		wr(R_CMD, c);
		chk("acc", macc, acc);
		chk("flags", {25'h0, mfl}, {25'h0, flags});
	endtask : run_cmd

	// Main sequence
	initial begin
		logic [1:0] w, lh, ah;
		logic [2:0] imf;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk("acc after reset", ACC_RST, acc);
		rd("unmapped read", 8'h14, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		r = $random(seed);
		wr(R_FLAGS, {25'h0, r[6:0]});
		mfl = r[6:0];
		rd("flags reg", R_FLAGS, {25'h0, mfl});
		$display("test reset and registers done");
		// Random immediate loads and adds with every width, treatment and flag code
		for (int k = 0; k < 40; k++) begin
			r = $random(seed);
			imm = $random(seed);
			w = r[1:0];
			lh = (r[3:2] == 2'h3) ? LH_KEEP : r[3:2];
			ah = r[5:4];
			imf = r[8:6];
			if (imf == IMM_EXT8 && w[1]) w = W_WORD;
			if (w == W_WORD) lh = LH_KEEP;
			wr(R_IMM, imm);
			model(w, lh, ah, opval(imf, imm), r[22:9], r[23]);
			run_cmd(cmd(w, lh, ah, 1'b0, r[23], r[22:9], SRC_IMM, 3'h0, imf));
		end
		rd("acc reg", R_ACC, macc);
		$display("test immediate loads done");
		// Register file: word, byte and long views
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			wreg[k] = r[15:0];
			wr(8'(8'h40 + 4 * k), {16'h0, wreg[k]});
			rd("word reg", 8'(8'h40 + 4 * k), {16'h0, wreg[k]});
		end
		for (int k = 0; k < 8; k++) begin
			model(W_WORD, LH_KEEP, AH_SIGN, {16'h0, wreg[k]}, 14'h0, 1'b0);
			run_cmd(cmd(W_WORD, LH_KEEP, AH_SIGN, 1'b0, 1'b0, 14'h0, SRC_WORD, 3'(k), IMM_4));
			op = {24'h0, k[0] ? wreg[4 + k / 2][15:8] : wreg[4 + k / 2][7:0]};
			model(W_BYTE, LH_ZERO, AH_ZERO, op, 14'h0, 1'b0);
			run_cmd(cmd(W_BYTE, LH_ZERO, AH_ZERO, 1'b0, 1'b0, 14'h0, SRC_BYTE, 3'(k), IMM_4));
			if (k < 4) begin
				model(2'h2, LH_KEEP, AH_KEEP, {wreg[2 * k + 1], wreg[2 * k]}, 14'h0, 1'b0);
				run_cmd(cmd(2'h2, LH_KEEP, AH_KEEP, 1'b0, 1'b0, 14'h0, 2'h3, 3'(k), IMM_4));
			end
		end
		$display("test register sources done");
		// Read-modify-write on memory, byte then word; accumulator untouched
		// a plain memory word reads back what was written, so write-back is safe
		for (int k = 0; k < 2; k++) begin
			r = $random(seed);
			imm = $random(seed);
			wr(R_MEM_IDX, 32'h3);
			wr(R_MEM_DATA, {16'h0, r[15:0]});
			wr(R_IMM, imm);
			run_cmd(cmd(2'(k), LH_KEEP, AH_KEEP, 1'b1, 1'b1, 14'h0, SRC_IMM, 3'h0, k ? IMM_16 : IMM_8));
			op = k ? {16'h0, r[15:0] + imm[15:0]} : {16'h0, r[15:8], r[7:0] + imm[7:0]};
			rd("rmw memory", R_MEM_DATA, op);
		end
		$display("test read modify write done");
		// Address forming and vector decode in every mode
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			imm = $random(seed);
			wr(R_EA_CFG, {3'h0, k[0], imm[27:26], k[1:0], imm[23:0]});
			case (k[1:0])
				EA_IO: op = {24'h0, imm[23:16]};
				EA_DISP8: op = {16'h0, wreg[imm[27:26]] + {{8{imm[23]}}, imm[23:16]}};
				EA_DISP16: op = {16'h0, wreg[imm[27:26]] + imm[15:0]};
				default: op = {8'h0, imm[23:0]};
			endcase
			rd("effective address", R_EA_ADDR, op);
			rd("vector", R_VEC, k[0] ? {28'h0, imm[19:16]} : {24'h0, imm[23:16]});
		end
		$display("test addressing done");
		// Clock enable low stalls the slave; the request is held until it answers
		ce <= 1'b0;
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= R_ACC;
		pwdata <= ~macc;
		@(posedge clk);
		penable <= 1'b1;
		repeat (3) @(posedge clk);
		chk("stalled ready", 32'h0, {31'h0, pready});
		chk("frozen acc", macc, acc);
		ce <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		macc = ~macc;
		@(posedge clk);
		chk("acc after stall", macc, acc);
		$display("test clock enable done");
		// Bank groups: program bank only through group one
		wr(R_BANK, {16'h0, 8'h5a, 3'h0, 1'b1, 1'b0, BK_PROGRAM});
		chk("group one program", 32'h0, {31'h0, err});
		rd("program bank", R_BANK, {16'h0, 8'h5a, 5'h0, BK_PROGRAM});
		wr(R_BANK, {16'h0, 8'h11, 3'h0, 1'b1, 1'b1, 3'h6});
		chk("group two code 6", 32'h1, {31'h0, err});
		wr(R_BANK, {16'h0, 8'h22, 3'h0, 1'b1, 1'b1, BK_NONE});
		chk("group two code 7", 32'h1, {31'h0, err});
		wr(R_BANK, {16'h0, 8'h00, 3'h0, 1'b0, 1'b1, BK_DATA});
		chk("group two data", 32'h0, {31'h0, err});
		// Stack pointer and stack bank follow the stack select flag
		r = $random(seed);
		wr(R_SP, {16'h0, r[15:0]});
		rd("active stack pointer", R_SP, {16'h0, r[15:0]});
		mfl[FL_S] = ~mfl[FL_S];
		wr(R_FLAGS, {25'h0, mfl});
		rd("other stack pointer", R_SP, 32'h0);
		wr(R_BANK, {16'h0, 8'h33, 3'h0, 1'b1, 1'b1, 3'h5});
		chk("group two current stack", 32'h0, {31'h0, err});
		op = {29'h0, (mfl[FL_S] ? BK_SYS_STACK : BK_USER_STACK)};
		wr(R_BANK, {24'h0, 5'h0, op[2:0]});
		rd("current stack bank", R_BANK, {16'h0, 8'h33, 5'h0, op[2:0]});
		$display("test bank groups done");
		stop_test();
	end
endmodule : test_acc_operand_unit
`default_nettype wire
